// file: rtl/otp_programmer.sv
/*
 * Programmer for a 128K x 8 one-time-programmable memory: single reads,
 * identification reads and the pulse-and-verify programming of a range
 * with a final whole-range readback.
 * Assumes the memory pins are driven directly; supply switching is by the
 * vpp_high and id_mode_high level outputs to external drivers.
 */
`timescale 1ns/1ps
`include "otp_prog_params.svh"
module otp_programmer
    import otp_prog_pkg::*;
#(
    parameter int MAX_PULSES = `MAX_PULSES_DEF,
    parameter int SHORT_CYC = `SHORT_PULSE_CYC,
    parameter int LONG_CYC = `LONG_PULSE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    output logic req_ready,
    input wire req_t req,
    input wire logic [`ADDR_W-1:0] last_addr,
    output logic [`DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic fail,
    output logic [`ADDR_W-1:0] fail_addr,
    output logic id_parity_ok,
    output pins_t pins,
    input wire logic [`DATA_W-1:0] data_in
);
    typedef struct packed {
        state_t st;
        pins_t p;
        req_t q;
        logic [`ADDR_W-1:0] last;
        logic [16:0] cnt;
        logic [7:0] pulses;
        logic [`DATA_W-1:0] rd;
        logic rdv;
        logic fail;
        logic [`ADDR_W-1:0] faddr;
        logic par;
        logic [16:0] low_cnt;
    } regs_t;

    localparam logic [16:0] ACC_CYC = 17'(`ACCESS_DELAY_CYC);
    regs_t r, n;

    function automatic pins_t idle_pins();
        pins_t v;
        v = '0;
        v.chip_select_n = 1'b1;
        v.output_gate_n = 1'b1;
        v.program_strobe_n = 1'b1;
        return v;
    endfunction

    always_comb begin
        n = r;
        n.rdv = 1'b0;
        case (r.st)
            st_idle: begin
                n.p = idle_pins();
                if (req_valid) begin
                    n.q = req;
                    n.last = last_addr;
                    n.fail = 1'b0;
                    n.pulses = '0;
                    n.cnt = '0;
                    n.p.word_address = req.addr;
                    if (req.kind == cmd_program) begin
                        // Supply up with strobe idle; select falls with the pulse
                        n.p.vpp_high = 1'b1;
                        n.p.data_out = req.data;
                        n.p.data_oe = 1'b1;
                        n.st = st_pulse;
                        n.cnt = '0;
                    end else begin
                        if (req.kind == cmd_ident) begin
                            n.p.word_address = '0;
                            n.p.word_address[`ID_BANK_BIT] = req.addr[`ID_BANK_BIT];
                            n.p.word_address[`ID_BYTE_BIT] = req.addr[`ID_BYTE_BIT];
                            n.p.id_mode_high = 1'b1;
                        end
                        n.p.chip_select_n = 1'b0;
                        n.p.output_gate_n = 1'b0;
                        n.st = st_access;
                    end
                end
            end
            st_access: begin
                n.cnt = r.cnt + 17'd1;
                if (r.cnt + 17'd1 >= ACC_CYC) begin
                    n.rd = data_in;
                    n.rdv = 1'b1;
                    n.par = ^data_in;
                    n.p = idle_pins();
                    n.st = st_idle;
                end
            end
            st_pulse: begin
                n.p.chip_select_n = 1'b0;
                n.p.program_strobe_n = 1'b0;
                n.cnt = r.cnt + 17'd1;
                // Strobe goes low one edge after entry, so release once the full width has run
                if (r.cnt >= (r.q.long_pulse ? 17'(LONG_CYC) : 17'(SHORT_CYC))) begin
                    n.p.program_strobe_n = 1'b1;
                    n.p.chip_select_n = 1'b1;
                    n.p.data_oe = 1'b0;
                    n.pulses = r.pulses + 8'd1;
                    n.cnt = '0;
                    n.st = st_verify_setup;
                end
            end
            st_verify_setup: begin
                n.p.chip_select_n = 1'b0;
                n.p.output_gate_n = 1'b0;
                n.cnt = '0;
                n.st = st_verify;
            end
            st_verify: begin
                n.cnt = r.cnt + 17'd1;
                if (r.cnt + 17'd1 >= ACC_CYC) begin
                    n.p.chip_select_n = 1'b1;
                    n.p.output_gate_n = 1'b1;
                    n.cnt = '0;
                    if (data_in == r.q.data) begin
                        n.st = st_next;
                    end else if (32'(r.pulses) >= MAX_PULSES) begin
                        n.fail = 1'b1;
                        n.faddr = r.p.word_address;
                        n.p = idle_pins();
                        n.st = st_done;
                    end else begin
                        n.p.data_oe = 1'b1;
                        n.st = st_pulse;
                    end
                end
            end
            st_next: begin
                n.pulses = '0;
                if (r.p.word_address >= r.last) begin
                    n.p.word_address = r.q.addr;
                    n.p.vpp_high = 1'b0;
                    n.st = st_final_setup;
                end else begin
                    // Same byte for the whole range; the caller reloads per run
                    n.p.word_address = r.p.word_address + 17'd1;
                    n.p.data_oe = 1'b1;
                    n.st = st_pulse;
                end
            end
            st_final_setup: begin
                n.p.chip_select_n = 1'b0;
                n.p.output_gate_n = 1'b0;
                n.cnt = '0;
                n.st = st_final;
            end
            st_final: begin
                n.cnt = r.cnt + 17'd1;
                if (r.cnt + 17'd1 >= ACC_CYC) begin
                    n.cnt = '0;
                    if (data_in != r.q.data) begin
                        n.fail = 1'b1;
                        n.faddr = r.p.word_address;
                        n.p = idle_pins();
                        n.st = st_done;
                    end else if (r.p.word_address >= r.last) begin
                        n.p = idle_pins();
                        n.st = st_done;
                    end else begin
                        n.p.word_address = r.p.word_address + 17'd1;
                    end
                end
            end
            st_done: begin
                n.st = st_idle;
            end
            default: begin
                n.st = st_idle;
            end
        endcase
        // Strobe low time, kept only for the pulse width checks
        n.low_cnt = r.p.program_strobe_n ? 17'd0 : r.low_cnt + 17'd1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.st <= st_idle;
            r.p.chip_select_n <= 1'b1;
            r.p.output_gate_n <= 1'b1;
            r.p.program_strobe_n <= 1'b1;
            r.rd <= `ERASED_BYTE;
        end else begin
            r <= n;
        end
    end

    assign req_ready = (r.st == st_idle);
    assign pins = r.p;
    assign rd_data = r.rd;
    assign rd_valid = r.rdv;
    assign busy = (r.st != st_idle);
    assign fail = r.fail;
    assign fail_addr = r.faddr;
    assign id_parity_ok = r.par;

    prog_needs_vpp_a: assert property (@(posedge clk) disable iff (reset)
        !pins.program_strobe_n |-> pins.vpp_high && pins.output_gate_n && !pins.chip_select_n && pins.data_oe)
        else $error("Program strobe without full program conditions");
    no_contention_a: assert property (@(posedge clk) disable iff (reset)
        !pins.output_gate_n |-> !pins.data_oe && !pins.chip_select_n)
        else $error("Gate low while driving data or deselected");
    pulse_width_a: assert property (@(posedge clk) disable iff (reset)
        $fell(pins.program_strobe_n) && !r.q.long_pulse |-> !pins.program_strobe_n [*8])
        else $error("Short pulse ended early");
    pulse_end_a: assert property (@(posedge clk) disable iff (reset)
        r.low_cnt <= 17'(LONG_CYC))
        else $error("Program pulse too long");
    pulse_exact_a: assert property (@(posedge clk) disable iff (reset)
        (pins.program_strobe_n && r.low_cnt != 17'd0) |->
            (r.low_cnt == 17'(SHORT_CYC) || r.low_cnt == 17'(LONG_CYC)))
        else $error("Program pulse not of a fixed width");
    verify_after_a: assert property (@(posedge clk) disable iff (reset)
        $rose(pins.program_strobe_n) |-> ##1 (!pins.output_gate_n && pins.vpp_high))
        else $error("No verify read after pulse");
    pulse_limit_a: assert property (@(posedge clk) disable iff (reset)
        (r.st == st_pulse) |-> 32'(r.pulses) < MAX_PULSES)
        else $error("Pulse count beyond limit");
    ident_addr_a: assert property (@(posedge clk) disable iff (reset)
        pins.id_mode_high |-> pins.word_address[16:2] == '0)
        else $error("Identification with other address lines set");
    read_time_a: assert property (@(posedge clk) disable iff (reset)
        (r.st == st_idle && req_valid && req.kind != cmd_program) |-> ##6 rd_valid)
        else $error("Read answer not at access delay");
endmodule

// file: rtl/otp_prog_params.svh
/*
 * Constants for the one-time-programmable memory programmer.
 * Assumes a 100 MHz clock; included by the package and the module.
 */
`ifndef OTP_PROG_PARAMS_SVH
`define OTP_PROG_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define SHORT_PULSE_US 20
`define LONG_PULSE_US 100
`define SHORT_PULSE_CYC ((`SHORT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define LONG_PULSE_CYC ((`LONG_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define ACCESS_DELAY_NS 45
`define ACCESS_DELAY_CYC ((`ACCESS_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 17
`define DATA_W 8
`define ID_MODE_BIT 9
`define ID_BANK_BIT 1
`define ID_BYTE_BIT 0
`define MAX_PULSES_DEF 25
`define ERASED_BYTE 8'hff
`endif

// file: rtl/otp_prog_pkg.sv
/*
 * Types for the programmer: pin bundle, requests and machine states.
 * Assumes the params header sits beside it.
 */
`include "otp_prog_params.svh"
package otp_prog_pkg;
    typedef enum logic [1:0] {cmd_read, cmd_program, cmd_ident} cmd_kind_t;
    typedef struct packed {
        logic [`ADDR_W-1:0] word_address;
        logic chip_select_n;
        logic output_gate_n;
        logic program_strobe_n;
        logic vpp_high;
        logic id_mode_high;
        logic [`DATA_W-1:0] data_out;
        logic data_oe;
    } pins_t;
    typedef struct packed {
        cmd_kind_t kind;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
        logic long_pulse;
    } req_t;
    typedef enum logic [3:0] {
        st_idle, st_access, st_pulse, st_verify_setup, st_verify, st_next,
        st_final_setup, st_final, st_done
    } state_t;
endpackage

// file: bench/otp_mem_model.sv
/*
 * Behavioural model of the 128K x 8 one-time-programmable memory.
 * Assumes it sees the programmer's registered pin bundle on the same clock.
 */
`timescale 1ns/1ps
module otp_mem_model
    import otp_prog_pkg::*;
#(
    parameter int SHORT_CYC = 8,
    parameter int LONG_CYC = 20,
    parameter logic [16:0] STUCK_ADDR = 17'h0_0010,
    // Identifier values are arbitrary, each with odd parity
    parameter logic [7:0] MAKER_ID = 8'h23,
    parameter logic [7:0] TYPE_ID = 8'h02,
    parameter logic [7:0] CONT_ID = 8'h0e
) (
    input wire clk,
    input wire pins_t pins,
    output logic [7:0] data_q,
    output int pulse_count,
    output int width_errors
);
    logic [7:0] mem [logic [16:0]];
    int tries [logic [16:0]];
    pins_t prev = '0;
    int settle = 0;
    int low_len = 0;
    logic [7:0] val;
    logic [16:0] a;
    initial begin
        data_q = 8'h00;
        pulse_count = 0;
        width_errors = 0;
    end
    always @(posedge clk) begin
        a = pins.word_address;
        if (pins.id_mode_high && a[16:2] == 15'h0000) begin
            val = a[1] ? (a[0] ? TYPE_ID : MAKER_ID) : CONT_ID;
        end else begin
            val = mem.exists(a) ? mem[a] : 8'hff;
        end
        settle = (a != prev.word_address || pins.chip_select_n != prev.chip_select_n ||
                  pins.output_gate_n != prev.output_gate_n) ? 0 : settle + 1;
        // Undriven or unsettled lines toggle so stale data never passes
        data_q <= (!pins.chip_select_n && !pins.output_gate_n && settle >= 1) ? val : ~data_q;
        if (!pins.chip_select_n && pins.output_gate_n && !pins.program_strobe_n && pins.vpp_high) begin
            low_len++;
        end
        if (!prev.program_strobe_n && pins.program_strobe_n && !prev.chip_select_n && prev.vpp_high &&
            prev.output_gate_n && prev.data_oe) begin
            pulse_count++;
            if (low_len != SHORT_CYC && low_len != LONG_CYC) begin
                width_errors++;
            end
            a = prev.word_address;
            tries[a] = tries.exists(a) ? tries[a] + 1 : 1;
            // Odd addresses need two pulses, one address never takes
            if (a != STUCK_ADDR && tries[a] >= (a[0] ? 2 : 1)) begin
                mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & prev.data_out;
            end
            low_len = 0;
        end
        prev = pins;
    end
endmodule

// file: bench/tb_top.sv
/*
 * Self-checking bench for the memory programmer with a memory model.
 * Assumes the design package and the model are compiled first.
 */
`timescale 1ns/1ps
module tb_top
    import otp_prog_pkg::*;
;
    localparam int MAXP = 4;
    localparam logic [16:0] STUCK = 17'h0_0010;
    localparam logic [7:0] ID_TAB [4] = '{8'h0e, 8'h0e, 8'h23, 8'h02};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    req_t req = '0;
    logic [16:0] last_addr = '0;
    logic [7:0] data_in;
    logic req_ready, rd_valid, busy, fail, id_parity_ok;
    logic [7:0] rd_data;
    logic [16:0] fail_addr;
    pins_t pins;
    int pulses, width_err, p0;
    int fail_count = 0;
    int tests_run = 0;
    logic [7:0] d;

    otp_programmer #(.MAX_PULSES(MAXP), .SHORT_CYC(8), .LONG_CYC(20)) dut_u (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .last_addr(last_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy(busy), .fail(fail), .fail_addr(fail_addr), .id_parity_ok(id_parity_ok),
        .pins(pins), .data_in(data_in));
    otp_mem_model #(.SHORT_CYC(8), .LONG_CYC(20), .STUCK_ADDR(STUCK), .MAKER_ID(ID_TAB[2]),
        .TYPE_ID(ID_TAB[3]), .CONT_ID(ID_TAB[0])) mem_u (.clk(clk), .pins(pins), .data_q(data_in),
        .pulse_count(pulses), .width_errors(width_err));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic conclude;
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic send(input cmd_kind_t k, input logic [16:0] a, input logic [7:0] dv, input logic lp);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        req = '{kind: k, addr: a, data: dv, long_pulse: lp};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    task automatic read_byte(input cmd_kind_t k, input logic [16:0] a, output logic [7:0] dv);
        int n;
        send(k, a, 8'h00, 1'b0);
        n = 0;
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("rd_valid", 17'(rd_valid), 17'h0_0001);
        dv = rd_data;
    endtask

    task automatic run_prog(input logic [16:0] a, input logic [16:0] la, input logic [7:0] dv, input logic lp);
        int n;
        last_addr = la;
        p0 = pulses;
        send(cmd_program, a, dv, lp);
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check("busy", 17'(busy), 17'h0_0000);
    endtask

    task automatic sc_reset;
        check("idle_pins", 17'({pins.chip_select_n, pins.output_gate_n, pins.program_strobe_n, pins.vpp_high,
            pins.id_mode_high, pins.data_oe}), 17'h0_0038);
        check("rd_data", 17'(rd_data), 17'h0_00ff);
        check("req_ready", 17'(req_ready), 17'h0_0001);
    endtask

    task automatic sc_erased;
        read_byte(cmd_read, 17'h1_ffff, d);
        check("erased", 17'(d), 17'h0_00ff);
        check("standby", 17'(pins.chip_select_n), 17'h0_0001);
    endtask

    task automatic sc_ident;
        for (int i = 0; i < 4; i++) begin
            read_byte(cmd_ident, 17'(i), d);
            check("ident", 17'(d), 17'(ID_TAB[i]));
            check("parity", 17'(id_parity_ok), 17'h0_0001);
        end
    endtask

    task automatic sc_program;
        run_prog(17'h0_0004, 17'h0_0005, 8'h5a, 1'b0);
        check("fail", 17'(fail), 17'h0_0000);
        check("pulses", 17'(pulses - p0), 17'h0_0003);
        run_prog(17'h0_0007, 17'h0_0007, 8'h3c, 1'b1);
        check("width", 17'(width_err), 17'h0_0000);
        read_byte(cmd_read, 17'h0_0004, d);
        check("prog4", 17'(d), 17'h0_005a);
        read_byte(cmd_read, 17'h0_0005, d);
        check("prog5", 17'(d), 17'h0_005a);
        read_byte(cmd_read, 17'h0_0007, d);
        check("prog7", 17'(d), 17'h0_003c);
        read_byte(cmd_read, 17'h0_0006, d);
        check("untouched", 17'(d), 17'h0_00ff);
    endtask

    task automatic sc_fail;
        run_prog(STUCK, STUCK, 8'h00, 1'b1);
        check("fail", 17'(fail), 17'h0_0001);
        check("fail_addr", fail_addr, STUCK);
        check("pulses", 17'(pulses - p0), 17'(MAXP));
        read_byte(cmd_read, STUCK, d);
        check("fail_clr", 17'(fail), 17'h0_0000);
        check("stuck", 17'(d), 17'h0_00ff);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        sc_reset;
        sc_erased;
        sc_ident;
        sc_program;
        sc_fail;
        conclude;
    end

    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        fail_count++;
        conclude;
    end
endmodule
